// [pkg/ssrq_pkg.sv]
// Constants, types and field layout for the status and service request block.
// Assumes a single 125 MHz clock domain shared with the command parser.
package ssrq_pkg;

	// ==========================================================
	// Register width and bit positions
	localparam int REG_W   = 8;
	localparam int POS_OPC = 0;	// Operation complete
	localparam int POS_QYE = 2;	// Query error
	localparam int POS_EXE = 4;	// Execution error
	localparam int POS_CME = 5;	// Command error
	localparam int POS_PON = 7;	// Power on
	localparam int POS_ESB = 5;	// Event summary in status byte
	localparam int POS_MSS = 6;	// Request service / master summary

	// ==========================================================
	// Reset values
	localparam logic [REG_W-1:0] EVT_RESET = 8'h80;	// Only power-on set
	localparam logic [REG_W-1:0] ENA_RESET = 8'h00;
	localparam logic [REG_W-1:0] REG_ZERO  = 8'h00;

	// ==========================================================
	// Decimal conversion divisors
	localparam logic [REG_W-1:0] DEC_HUNDRED = 8'h64;
	localparam logic [REG_W-1:0] DEC_TEN     = 8'h0A;

	// ==========================================================
	// Host operations delivered by the command parser
	typedef enum logic [2:0] {
		OP_EVT_ENA_WR,
		OP_EVT_ENA_QRY,
		OP_SRQ_ENA_WR,
		OP_SRQ_ENA_QRY,
		OP_EVT_QRY,
		OP_STB_QRY,
		OP_CLEAR_ALL
	} ssrq_op_t;

	typedef struct packed {
		logic             valid;
		ssrq_op_t         op;
		logic [REG_W-1:0] data;
	} ssrq_cmd_t;

	// Event pulses raised by the instrument
	typedef struct packed {
		logic cmdErr;
		logic execErr;
		logic queryErr;
		logic opComplete;
	} ssrq_evt_t;

	// Response handed to the talker
	typedef struct packed {
		logic             valid;
		logic [REG_W-1:0] value;
		logic [3:0]       hundreds;
		logic [3:0]       tens;
		logic [3:0]       ones;
	} ssrq_rsp_t;

endpackage : ssrq_pkg

// [design/ssrq_status.sv]
// Status system: event latch, enables, status byte, service request, query answers.
// Assumes commands, events and talk state come from logic on sys_clk.
`timescale 1ns/100ps

module ssrq_status (
	// Clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      reset,
	// Parsed host operations and instrument events
	input  wire ssrq_pkg::ssrq_cmd_t       hostCmd,
	input  wire ssrq_pkg::ssrq_evt_t       events,
	input  wire logic [ssrq_pkg::REG_W-1:0] auxSummary,
	// Bus state
	input  wire logic                      talkAddressed,
	input  wire logic                      hostListening,
	input  wire logic                      serialPoll,
	input  wire logic                      rspTaken,
	// Results
	output ssrq_pkg::ssrq_rsp_t            rsp_ff,
	output logic [ssrq_pkg::REG_W-1:0]     statusByte_ff,
	output logic [ssrq_pkg::REG_W-1:0]     pollByte_ff,
	output logic                           srqAssert_ff
);
	import ssrq_pkg::*;

	// ==========================================================
	// State
	logic [REG_W-1:0] evtReg_ff, nxt_evtReg;
	logic [REG_W-1:0] evtEna_ff, nxt_evtEna;
	logic [REG_W-1:0] srqEna_ff, nxt_srqEna;
	logic             mssPrev_ff, nxt_mssPrev;
	logic             pend_ff, nxt_pend;
	logic [REG_W-1:0] pendVal_ff, nxt_pendVal;
	ssrq_rsp_t        nxt_rsp;
	logic [REG_W-1:0] nxt_statusByte;
	logic [REG_W-1:0] nxt_pollByte;
	logic             nxt_srqAssert;

	// Combinational helpers
	logic [REG_W-1:0] evtSet;
	logic             clearEvt;
	logic             evtSummary;
	logic [REG_W-1:0] stbLow;
	logic             mss;
	logic [REG_W-1:0] stbNow;
	logic             talkOpen;
	logic             isQuery;

	// Binary to three decimal digits for the response text
	function automatic logic [11:0] to_decimal(input logic [REG_W-1:0] v);
		logic [REG_W-1:0] h;
		logic [REG_W-1:0] r;
		logic [REG_W-1:0] t;
		logic [REG_W-1:0] o;
		h = v / DEC_HUNDRED;
		r = v % DEC_HUNDRED;
		t = r / DEC_TEN;
		o = r % DEC_TEN;
		return {h[3:0], t[3:0], o[3:0]};
	endfunction : to_decimal

	// ==========================================================
	// Summary path, purely combinational
	always_comb begin
		evtSet             = REG_ZERO;
		evtSet[POS_CME]    = events.cmdErr;
		evtSet[POS_EXE]    = events.execErr;
		evtSet[POS_QYE]    = events.queryErr;
		evtSet[POS_OPC]    = events.opComplete;
		evtSummary         = |(evtReg_ff & evtEna_ff);
		stbLow             = auxSummary;
		stbLow[POS_ESB]    = evtSummary;
		stbLow[POS_MSS]    = 1'b0;
		mss                = |(stbLow & srqEna_ff);
		stbNow             = stbLow;
		stbNow[POS_MSS]    = mss;
		talkOpen           = talkAddressed && hostListening;
		isQuery            = hostCmd.valid && ((hostCmd.op == OP_EVT_ENA_QRY) ||
			(hostCmd.op == OP_SRQ_ENA_QRY) || (hostCmd.op == OP_EVT_QRY) ||
			(hostCmd.op == OP_STB_QRY));
		clearEvt           = hostCmd.valid &&
			((hostCmd.op == OP_EVT_QRY) || (hostCmd.op == OP_CLEAR_ALL));
	end

	// ==========================================================
	// Next state
	always_comb begin
		// Event bits: a new event in the clearing cycle survives the clear
		nxt_evtReg  = (evtReg_ff & ~{REG_W{clearEvt}}) | evtSet;
		nxt_evtEna  = evtEna_ff;
		nxt_srqEna  = srqEna_ff;
		nxt_pend    = pend_ff;
		nxt_pendVal = pendVal_ff;
		nxt_rsp     = rsp_ff;
		nxt_mssPrev = mss;
		// Status byte has no clear of its own, it only mirrors summaries
		nxt_statusByte = stbNow;
		// Request service: edge of master summary sets, poll clears, set wins
		nxt_srqAssert = (srqAssert_ff && !serialPoll) || (mss && !mssPrev_ff);
		nxt_pollByte  = stbNow;
		nxt_pollByte[POS_MSS] = nxt_srqAssert;

		// Drop an offered response once taken or when talking ends
		if (rsp_ff.valid && (rspTaken || !talkOpen)) begin
			nxt_rsp.valid = 1'b0;
		end
		// Offer the pending answer only once addressed to talk
		if (pend_ff && talkOpen && !rsp_ff.valid) begin
			nxt_rsp.valid = 1'b1;
			nxt_rsp.value = pendVal_ff;
			{nxt_rsp.hundreds, nxt_rsp.tens, nxt_rsp.ones} = to_decimal(pendVal_ff);
			nxt_pend = 1'b0;
		end

		if (hostCmd.valid) begin
			unique case (hostCmd.op)
				OP_EVT_ENA_WR:  nxt_evtEna  = hostCmd.data;
				OP_SRQ_ENA_WR:  nxt_srqEna  = hostCmd.data;
				OP_EVT_ENA_QRY: nxt_pendVal = evtEna_ff;
				OP_SRQ_ENA_QRY: nxt_pendVal = srqEna_ff;
				OP_EVT_QRY:     nxt_pendVal = evtReg_ff;
				OP_STB_QRY:     nxt_pendVal = stbNow;
				OP_CLEAR_ALL:   nxt_pendVal = pendVal_ff;
				default:        nxt_pendVal = pendVal_ff;
			endcase
		end
		// A later query replaces any unanswered one
		if (isQuery) begin
			nxt_pend = 1'b1;
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			evtReg_ff     <= EVT_RESET;
			evtEna_ff     <= ENA_RESET;
			srqEna_ff     <= ENA_RESET;
			mssPrev_ff    <= 1'b0;
			pend_ff       <= 1'b0;
			pendVal_ff    <= REG_ZERO;
			rsp_ff        <= '0;
			statusByte_ff <= REG_ZERO;
			pollByte_ff   <= REG_ZERO;
			srqAssert_ff  <= 1'b0;
		end else begin
			evtReg_ff     <= nxt_evtReg;
			evtEna_ff     <= nxt_evtEna;
			srqEna_ff     <= nxt_srqEna;
			mssPrev_ff    <= nxt_mssPrev;
			pend_ff       <= nxt_pend;
			pendVal_ff    <= nxt_pendVal;
			rsp_ff        <= nxt_rsp;
			statusByte_ff <= nxt_statusByte;
			pollByte_ff   <= nxt_pollByte;
			srqAssert_ff  <= nxt_srqAssert;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence s_queryIn;
		isQuery;
	endsequence

	sequence s_talkOpen;
		pend_ff && talkOpen && !rsp_ff.valid;
	endsequence

	a_event_latch: assert property (events.cmdErr |=> evtReg_ff[POS_CME])
		else $error("command error event not latched");
	a_event_hold: assert property (evtReg_ff[POS_EXE] && !clearEvt |=> evtReg_ff[POS_EXE])
		else $error("set event bit lost without clear");
	a_only_clear: assert property ((|(evtReg_ff & ~nxt_evtReg)) |-> clearEvt)
		else $error("event bit fell without clear");
	a_esb_follow: assert property (1'b1 |=> statusByte_ff[POS_ESB] == $past(evtSummary))
		else $error("event summary not mirrored");
	a_ena_load: assert property (hostCmd.valid && hostCmd.op == OP_SRQ_ENA_WR
		|=> srqEna_ff == $past(hostCmd.data))
		else $error("enable register not loaded");
	a_mss_bit: assert property (1'b1 |=> statusByte_ff[POS_MSS] ==
		$past(|(stbLow & srqEna_ff)))
		else $error("master summary wrong");
	a_srq_rise: assert property (mss && !mssPrev_ff |=> srqAssert_ff)
		else $error("service request not raised");
	a_poll_clear: assert property (serialPoll && !(mss && !mssPrev_ff) && mss
		|=> !srqAssert_ff && statusByte_ff[POS_MSS])
		else $error("poll handling of request service wrong");
	a_esr_clear: assert property (hostCmd.valid && hostCmd.op == OP_EVT_QRY &&
		!(|evtSet) |=> evtReg_ff == REG_ZERO ##1 !statusByte_ff[POS_ESB])
		else $error("event query did not clear");
	a_talk_gate: assert property (!talkOpen |=> !$rose(rsp_ff.valid))
		else $error("response offered while not talker");
	// The offered value is whatever the most recent query left pending
	a_latest: assert property (s_talkOpen |=> rsp_ff.value == $past(pendVal_ff))
		else $error("response not from latest query");
	a_decimal: assert property ($rose(rsp_ff.valid) |-> rsp_ff.hundreds * 100 +
		rsp_ff.tens * 10 + rsp_ff.ones == rsp_ff.value)
		else $error("decimal digits wrong");

	// ==========================================================
	// Further checks on clearing, enables, request line and answers

	// Clear-status empties every event bit unless an event lands that cycle
	a_clear_all: assert property (hostCmd.valid && hostCmd.op == OP_CLEAR_ALL &&
		!(|evtSet) |=> evtReg_ff == REG_ZERO)
		else $error("clear-status did not clear events");
	// Every raised event is held in its bit one cycle later
	a_evt_set: assert property ((|evtSet)
		|=> (evtReg_ff & $past(evtSet)) == $past(evtSet))
		else $error("raised event not held");
	// Event enable register loads the written value
	a_evt_ena: assert property (hostCmd.valid && hostCmd.op == OP_EVT_ENA_WR
		|=> evtEna_ff == $past(hostCmd.data))
		else $error("event enable not loaded");
	// Enables change only through their own write operation
	a_ena_keep: assert property (!(hostCmd.valid && hostCmd.op == OP_EVT_ENA_WR)
		|=> $stable(evtEna_ff))
		else $error("event enable changed without write");
	a_sre_keep: assert property (!(hostCmd.valid && hostCmd.op == OP_SRQ_ENA_WR)
		|=> $stable(srqEna_ff))
		else $error("request enable changed without write");
	// Request line holds until a poll clears it
	a_srq_hold: assert property (srqAssert_ff && !serialPoll |=> srqAssert_ff)
		else $error("service request dropped without poll");
	// Request line rises only on a master summary edge
	a_srq_cause: assert property (!srqAssert_ff && !(mss && !mssPrev_ff)
		|=> !srqAssert_ff)
		else $error("service request raised without cause");
	// Status byte is a pure delayed copy, nothing clears it on its own
	a_stb_copy: assert property (1'b1 |=> statusByte_ff == $past(stbNow))
		else $error("status byte not a copy of summaries");
	// Poll byte shares the event summary bit of the status byte
	a_poll_esb: assert property (1'b1
		|=> pollByte_ff[POS_ESB] == statusByte_ff[POS_ESB])
		else $error("poll byte summary differs");
	// Taken answer is withdrawn at once
	a_rsp_drop: assert property (rsp_ff.valid && rspTaken |=> !rsp_ff.valid)
		else $error("taken answer still offered");
	// Offered answer stands while talking and not yet taken
	a_rsp_stand: assert property (rsp_ff.valid && !rspTaken && talkOpen
		|=> rsp_ff.valid)
		else $error("answer withdrawn early");
	// A query without talk addressing offers nothing
	a_query_wait: assert property (s_queryIn ##1 !talkOpen |=> !rsp_ff.valid)
		else $error("answer offered without talk");
	// Event query reads the register before it is cleared
	a_esr_value: assert property (hostCmd.valid && hostCmd.op == OP_EVT_QRY
		|=> pendVal_ff == $past(evtReg_ff))
		else $error("event query value wrong");
	// Reset leaves only power-on set and the request line low
	a_reset_state: assert property (disable iff (1'b0) reset
		|=> evtReg_ff == EVT_RESET && !srqAssert_ff && srqEna_ff == ENA_RESET)
		else $error("reset state wrong");

endmodule : ssrq_status

// [testbench/ssrq_host_model.sv]
// Bus controller host model: listens while the device talks and takes each answer.
// Assumes the bench drives talk and listen state on the block's clock.
`timescale 1ns/100ps
module ssrq_host_model (
	// Clock and reset
	input  wire logic                sys_clk,
	input  wire logic                reset,
	// Device answer and bus state
	input  wire ssrq_pkg::ssrq_rsp_t rsp,
	input  wire logic                talkAddressed,
	input  wire logic                hostListening,
	// Consumed answers
	output logic                     rspTaken_ff,
	output ssrq_pkg::ssrq_rsp_t      got_ff,
	output logic [7:0]               gotCnt_ff
);
	import ssrq_pkg::*;
	logic       nxt_rspTaken;
	ssrq_rsp_t  nxt_got;
	logic [7:0] nxt_gotCnt;
	// =========================================
	// Take an answer only as listener; guard stops a double take
	always_comb begin
		nxt_rspTaken = rsp.valid && talkAddressed && hostListening && !rspTaken_ff;
		nxt_got      = nxt_rspTaken ? rsp : got_ff;
		nxt_gotCnt   = gotCnt_ff + {7'h00, nxt_rspTaken};
	end
	// Register the consumption state
	always_ff @(posedge sys_clk) begin
		rspTaken_ff <= reset ? 1'b0 : nxt_rspTaken;
		got_ff      <= reset ? '0 : nxt_got;
		gotCnt_ff   <= reset ? 8'h00 : nxt_gotCnt;
	end
endmodule : ssrq_host_model

// [testbench/status_srq_reporting_tb_top.sv]
// Self-checking bench for the status and service request block.
// Assumes the host model consumes answers; inputs move 1 ns after each edge.
`timescale 1ns/100ps
module status_srq_reporting_tb_top;
	import ssrq_pkg::*;
	logic sys_clk = 0, reset = 1, talk = 0, listen = 0, poll = 0, taken;
	ssrq_cmd_t hostCmd = '0;
	ssrq_evt_t events = '0;
	logic [7:0] aux = 8'h00, sb, pb, cnt0;
	logic srq;
	ssrq_rsp_t rsp, got;
	logic [7:0] gotCnt;
	int error_cnt = 0, n_checks = 0, cycles = 0;
	ssrq_status uut (.sys_clk(sys_clk), .reset(reset), .hostCmd(hostCmd), .events(events),
		.auxSummary(aux), .talkAddressed(talk), .hostListening(listen), .serialPoll(poll),
		.rspTaken(taken), .rsp_ff(rsp), .statusByte_ff(sb), .pollByte_ff(pb), .srqAssert_ff(srq));
	ssrq_host_model host (.sys_clk(sys_clk), .reset(reset), .rsp(rsp), .talkAddressed(talk),
		.hostListening(listen), .rspTaken_ff(taken), .got_ff(got), .gotCnt_ff(gotCnt));
	// =========================================
	// Clock and hang guard; ceiling is far above the roughly 125 cycles needed
	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			error_cnt++;
			complete_run();
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc
	task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk
	task automatic cmd(input ssrq_op_t op, input logic [7:0] d);
		hostCmd = '{1'b1, op, d};
		cyc(1);
		hostCmd.valid = 1'b0;
		cyc(1);
	endtask : cmd
	task automatic pulse(input ssrq_evt_t e);
		events = e;
		cyc(1);
		events = '0;
	endtask : pulse
	// Answer must wait for talk; then host collects it as listener
	task automatic collect(input int exp);
		cyc(3);
		chk("early answer", {11'h000, rsp.valid}, 12'h000);
		cnt0 = gotCnt;
		talk = 1;
		listen = 1;
		for (int i = 0; i < 20 && gotCnt === cnt0; i++) cyc(1);
		chk("answer value", {4'h0, got.value}, exp[11:0]);
		chk("answer digits", {got.hundreds, got.tens, got.ones},
			{4'(exp / 100), 4'((exp / 10) % 10), 4'(exp % 10)});
		talk = 0;
		listen = 0;
		cyc(2);
	endtask : collect
	task automatic qry(input ssrq_op_t op, input int exp);
		cmd(op, 8'h00);
		collect(exp);
	endtask : qry
	// =========================================
	// Scenarios
	task automatic s_reset();
		chk("status byte", {4'h0, sb}, 12'h000);
		chk("srq", {11'h000, srq}, 12'h000);
		qry(OP_EVT_QRY, 128);
	endtask : s_reset
	task automatic s_enables();
		cmd(OP_EVT_ENA_WR, 8'h35);
		qry(OP_EVT_ENA_QRY, 53);
		cmd(OP_EVT_ENA_WR, 8'h00);
		qry(OP_EVT_ENA_QRY, 0);
		cmd(OP_SRQ_ENA_WR, 8'h20);
		qry(OP_SRQ_ENA_QRY, 32);
	endtask : s_enables
	task automatic s_srq();
		cmd(OP_EVT_ENA_WR, 8'h20);
		pulse(4'b1000);
		cyc(3);
		chk("status byte", {4'h0, sb}, 12'h060);
		chk("srq", {11'h000, srq}, 12'h001);
		chk("poll byte", {4'h0, pb}, 12'h060);
		poll = 1;
		cyc(1);
		poll = 0;
		cyc(2);
		chk("srq", {11'h000, srq}, 12'h000);
		chk("status byte", {4'h0, sb}, 12'h060);
		chk("poll byte", {4'h0, pb}, 12'h020);
		pulse(4'b1000);
		cyc(3);
		chk("srq", {11'h000, srq}, 12'h000);
		qry(OP_STB_QRY, 96);
		qry(OP_EVT_QRY, 32);
		chk("status byte", {4'h0, sb}, 12'h000);
	endtask : s_srq
	// Two queries back to back before talking: only the later one answers
	task automatic s_latest();
		cmd(OP_EVT_ENA_WR, 8'hFF);
		hostCmd = '{1'b1, OP_SRQ_ENA_QRY, 8'h00};
		cyc(1);
		hostCmd = '{1'b1, OP_EVT_ENA_QRY, 8'h00};
		cyc(1);
		hostCmd.valid = 1'b0;
		collect(255);
	endtask : s_latest
	task automatic s_clear();
		pulse(4'b0111);
		aux = 8'h10;
		cyc(3);
		chk("status byte", {4'h0, sb}, 12'h070);
		qry(OP_EVT_QRY, 21);
		pulse(4'b0111);
		cyc(1);
		cmd(OP_CLEAR_ALL, 8'hFF);
		cyc(3);
		chk("status byte", {4'h0, sb}, 12'h010);
		qry(OP_EVT_QRY, 0);
	endtask : s_clear
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run
	initial begin
		cyc(10);
		reset = 0;
		cyc(2);
		s_reset();
		s_enables();
		s_srq();
		s_latest();
		s_clear();
		complete_run();
	end
endmodule : status_srq_reporting_tb_top
